// File: core/t16wm_pkg.sv
// Shared constants for the 16-bit timer waveform and compare-output block.
// Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
package t16wm_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [4:0] T16WM_OFF_CTRL_A = 5'h00;
	localparam logic [4:0] T16WM_OFF_CTRL_B = 5'h04;
	localparam logic [4:0] T16WM_OFF_COUNT = 5'h08;
	localparam logic [4:0] T16WM_OFF_CMP_A = 5'h0c;
	localparam logic [4:0] T16WM_OFF_CMP_B = 5'h10;
	localparam logic [4:0] T16WM_OFF_CMP_C = 5'h14;
	localparam logic [4:0] T16WM_OFF_CAPTURE = 5'h18;
	localparam logic [4:0] T16WM_OFF_STATUS = 5'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int T16WM_POS_OUT_MODE_A = 6;
	localparam int T16WM_POS_OUT_MODE_B = 4;
	localparam int T16WM_POS_OUT_MODE_C = 2;
	localparam int T16WM_POS_WAVE_LOW = 0;
	localparam int T16WM_POS_WAVE_HIGH = 3;
	localparam int T16WM_POS_TICK_SEL = 0;
	localparam int T16WM_POS_OVF_FLAG = 0;
	localparam int T16WM_POS_MATCH_FLAG = 1;
	localparam int T16WM_POS_WAVE_STATE = 4;
	localparam int T16WM_POS_COUNT_UP = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] T16WM_RST_CTRL_A = 8'h00;
	localparam logic [4:0] T16WM_RST_CTRL_B = 5'h00;
	localparam logic [15:0] T16WM_RST_VALUE = 16'h0000;

	// ----------------------------------------------------------------
	// Counter limits and waveform modes
	// ----------------------------------------------------------------
	localparam logic [15:0] T16WM_TOP_8BIT = 16'h00ff;
	localparam logic [15:0] T16WM_TOP_9BIT = 16'h01ff;
	localparam logic [15:0] T16WM_TOP_10BIT = 16'h03ff;
	localparam logic [15:0] T16WM_MAX = 16'hffff;
	localparam logic [15:0] T16WM_BOTTOM = 16'h0000;
	localparam logic [3:0] T16WM_MODE_PFC_CMP = 4'h9;
	localparam logic [3:0] T16WM_MODE_PC_CMP = 4'hb;
	localparam logic [3:0] T16WM_MODE_FAST_CMP = 4'hf;

	// Tick source selections
	localparam logic [2:0] T16WM_TICK_STOP = 3'h0;
	localparam logic [2:0] T16WM_TICK_DIV1 = 3'h1;
	localparam logic [2:0] T16WM_TICK_DIV8 = 3'h2;
	localparam logic [2:0] T16WM_TICK_DIV64 = 3'h3;
	localparam logic [2:0] T16WM_TICK_DIV256 = 3'h4;
	localparam logic [2:0] T16WM_TICK_DIV1024 = 3'h5;
	localparam logic [2:0] T16WM_TICK_EXT_FALL = 3'h6;

	// Counting families selected by the waveform mode
	typedef enum logic [2:0] {
		T16WM_CLS_NORMAL = 3'b000,
		T16WM_CLS_CTC = 3'b001,
		T16WM_CLS_FAST = 3'b010,
		T16WM_CLS_PC = 3'b011,
		T16WM_CLS_PFC = 3'b100,
		T16WM_CLS_RSVD = 3'b101
	} t16wm_class_type;

endpackage

// File: core/t16wm_prescaler.sv
// Timer tick generator: divided I/O clock or filtered external pin edge.
// Assumes ext_pin is asynchronous; tick is a one-cycle clock enable.
`timescale 1ns/1ps
`default_nettype none
module t16wm_prescaler
	import t16wm_pkg::*;
#(
	parameter int PRESCALE_W = 10
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] tick_sel,
	input wire logic ext_pin,
	output logic tick
);

	// ----------------------------------------------------------------
	// Divider and pin synchroniser
	// ----------------------------------------------------------------
	initial begin
		if (PRESCALE_W < 10) begin
			$error("t16wm_prescaler: PRESCALE_W must reach the 1024 divide");
		end
	end

	logic [PRESCALE_W-1:0] div_reg;
	logic sync1_reg, sync2_reg, sync3_reg, pin_level_reg;
	logic agree, rise, fall;

	// Free-running divider; shared by every ratio so ticks stay aligned
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			pin_level_reg <= 1'b0;
		end else begin
			sync1_reg <= ext_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (agree) begin
				pin_level_reg <= sync3_reg;
			end
		end
	end

	assign agree = (sync2_reg == sync3_reg);
	assign rise = agree && sync3_reg && !pin_level_reg;
	assign fall = agree && !sync3_reg && pin_level_reg;

	// Tick selection; zero stops the counter
	always_comb begin
		case (tick_sel)
			T16WM_TICK_STOP: tick = 1'b0;
			T16WM_TICK_DIV1: tick = 1'b1;
			T16WM_TICK_DIV8: tick = &div_reg[2:0];
			T16WM_TICK_DIV64: tick = &div_reg[5:0];
			T16WM_TICK_DIV256: tick = &div_reg[7:0];
			T16WM_TICK_DIV1024: tick = &div_reg[9:0];
			T16WM_TICK_EXT_FALL: tick = fall;
			default: tick = rise;
		endcase
	end

endmodule
`default_nettype wire

// File: core/t16wm_core.sv
// 16-bit timer with waveform modes and three compare-output channels.
// Assumes an Avalon-MM master on clk; port mux data and direction come
// from the surrounding I/O port logic.
//
// Functional notes
// - Everything runs on clk; the timer tick is only an enable.
// - Output mode fields: channel A bits 7:6, B 5:4, C 3:2.
// - A connected output mode replaces the port data on its pin.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01 toggles channel A only in mode 15.
// - Fast PWM 10 clears on match, sets at BOTTOM; 11 inverts this.
// - Fast PWM 10/11 match at compare equal TOP ignored; BOTTOM action stays.
// - Dual-slope 01 toggles channel A only in modes 9 and 11.
// - Dual-slope 10 clears on up match, sets on down; 11 inverts.
// - Mode is control B high bits joined with control A bits 1:0.
// - Modes 1-3 phase correct, fixed TOP, load at TOP, flag BOTTOM.
// - Modes 5-7 fast PWM fixed TOP, load at TOP, flag at TOP.
// - Modes 0, 4, 12 load immediately and flag overflow at MAX.
// - Modes 8-9 load/flag at BOTTOM; 10-11 load TOP, flag BOTTOM.
// - Modes 14-15 fast PWM, capture or compare A TOP; 13 reserved.
// - BOTTOM events use the same tick relation as TOP events.
// - Dual-slope modes count up to TOP, then down to zero.
// - Tick select zero stops; else divided clock or external edge.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module t16wm_core
	import t16wm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_tick_pin,
	input wire logic [2:0] port_out,
	input wire logic [2:0] port_dir,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	output logic [2:0] wave_override
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic t16wm_class_type mode_class(input logic [3:0] m);
		case (m)
			4'h0: mode_class = T16WM_CLS_NORMAL;
			4'h4, 4'hc: mode_class = T16WM_CLS_CTC;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_class = T16WM_CLS_FAST;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: mode_class = T16WM_CLS_PC;
			4'h8, 4'h9: mode_class = T16WM_CLS_PFC;
			default: mode_class = T16WM_CLS_RSVD;
		endcase
	endfunction

	// Bus address match, used by every register write
	function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] off);
		reg_hit = (addr == off);
	endfunction

	// Whether output mode 01 may toggle this channel in this mode
	function automatic logic toggle_ok(input int ch, input t16wm_class_type cls, input logic [3:0] m);
		case (cls)
			T16WM_CLS_NORMAL, T16WM_CLS_CTC: toggle_ok = 1'b1;
			T16WM_CLS_FAST: toggle_ok = (ch == 0) && (m == T16WM_MODE_FAST_CMP);
			T16WM_CLS_PC, T16WM_CLS_PFC: toggle_ok = (ch == 0) && (m == T16WM_MODE_PFC_CMP || m == T16WM_MODE_PC_CMP);
			default: toggle_ok = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Registers and bus slave
	// ----------------------------------------------------------------
	logic [7:0] ctrl_a_reg;
	logic [4:0] ctrl_b_reg;
	logic [15:0] cnt_reg;
	logic up_reg;
	logic [15:0] cmp_buf_reg [3];
	logic [15:0] cmp_act_reg [3];
	logic [15:0] capture_reg;
	logic ovf_reg;
	logic [2:0] match_flag_reg;
	logic [2:0] wave_reg;
	wire [2:0] wave_next;
	logic block_reg;
	logic ack_reg;
	logic [31:0] readdata_reg;
	logic bus_wr;
	logic cnt_wr;
	logic tick;
	logic [3:0] mode;
	t16wm_class_type cls;
	logic [15:0] top;
	logic at_top, at_bottom, at_max, ovf_set, load_now;
	logic [2:0] match;
	logic [1:0] out_mode [3];
	logic [31:0] read_mux;

	// One wait cycle per request; the answer comes on the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign bus_wr = avs_write && ack_reg;
	assign cnt_wr = bus_wr && reg_hit(avs_address, T16WM_OFF_COUNT);
	assign avs_readdata = readdata_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
		end
	end

	// Read data captured one cycle ahead so it stands from a flop
	always_comb begin
		case (avs_address)
			T16WM_OFF_CTRL_A: read_mux = {24'h000000, ctrl_a_reg};
			T16WM_OFF_CTRL_B: read_mux = {27'h0000000, ctrl_b_reg};
			T16WM_OFF_COUNT: read_mux = {16'h0000, cnt_reg};
			T16WM_OFF_CMP_A: read_mux = {16'h0000, cmp_buf_reg[0]};
			T16WM_OFF_CMP_B: read_mux = {16'h0000, cmp_buf_reg[1]};
			T16WM_OFF_CMP_C: read_mux = {16'h0000, cmp_buf_reg[2]};
			T16WM_OFF_CAPTURE: read_mux = {16'h0000, capture_reg};
			T16WM_OFF_STATUS: read_mux = {24'h000000, up_reg, wave_reg, match_flag_reg, ovf_reg};
			default: read_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata_reg <= 32'h00000000;
		end else if (avs_read && !ack_reg) begin
			readdata_reg <= read_mux;
		end
	end

	// Control and top-source registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_a_reg <= T16WM_RST_CTRL_A;
			ctrl_b_reg <= T16WM_RST_CTRL_B;
			capture_reg <= T16WM_RST_VALUE;
		end else begin
			if (bus_wr && reg_hit(avs_address, T16WM_OFF_CTRL_A)) begin
				ctrl_a_reg <= avs_writedata[7:0];
			end
			if (bus_wr && reg_hit(avs_address, T16WM_OFF_CTRL_B)) begin
				ctrl_b_reg <= avs_writedata[4:0];
			end
			if (bus_wr && reg_hit(avs_address, T16WM_OFF_CAPTURE)) begin
				capture_reg <= avs_writedata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode decode and TOP selection
	// ----------------------------------------------------------------
	assign mode = {ctrl_b_reg[T16WM_POS_WAVE_HIGH +: 2], ctrl_a_reg[T16WM_POS_WAVE_LOW +: 2]};
	assign cls = mode_class(mode);
	assign out_mode[0] = ctrl_a_reg[T16WM_POS_OUT_MODE_A +: 2];
	assign out_mode[1] = ctrl_a_reg[T16WM_POS_OUT_MODE_B +: 2];
	assign out_mode[2] = ctrl_a_reg[T16WM_POS_OUT_MODE_C +: 2];

	// TOP uses the active compare A, so buffered modes see a stable period
	always_comb begin
		case (mode)
			4'h1, 4'h5: top = T16WM_TOP_8BIT;
			4'h2, 4'h6: top = T16WM_TOP_9BIT;
			4'h3, 4'h7: top = T16WM_TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top = cmp_act_reg[0];
			4'h8, 4'ha, 4'hc, 4'he: top = capture_reg;
			default: top = T16WM_MAX;
		endcase
	end

	t16wm_prescaler #(
		.PRESCALE_W(10)
	) u_prescaler (
		.clk(clk),
		.rst_b(rst_b),
		.tick_sel(ctrl_b_reg[T16WM_POS_TICK_SEL +: 3]),
		.ext_pin(ext_tick_pin),
		.tick(tick)
	);

	// Events are the tick in which the counter sits at the value
	assign at_top = tick && (cnt_reg == top);
	assign at_bottom = tick && (cnt_reg == T16WM_BOTTOM);
	assign at_max = tick && (cnt_reg == T16WM_MAX);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= T16WM_RST_VALUE;
			up_reg <= 1'b1;
		end else if (cnt_wr) begin
			cnt_reg <= avs_writedata[15:0];
		end else if (tick) begin
			case (cls)
				T16WM_CLS_PC, T16WM_CLS_PFC: begin
					if (up_reg && cnt_reg == top) begin
						up_reg <= 1'b0;
						cnt_reg <= (cnt_reg == T16WM_BOTTOM) ? T16WM_BOTTOM : 16'(cnt_reg - 16'h0001);
					end else if (up_reg) begin
						cnt_reg <= 16'(cnt_reg + 16'h0001);
					end else if (cnt_reg == T16WM_BOTTOM) begin
						up_reg <= 1'b1;
						cnt_reg <= (top == T16WM_BOTTOM) ? T16WM_BOTTOM : 16'h0001;
					end else begin
						cnt_reg <= 16'(cnt_reg - 16'h0001);
					end
				end
				default: begin
					up_reg <= 1'b1;
					cnt_reg <= (cnt_reg == top) ? T16WM_BOTTOM : 16'(cnt_reg + 16'h0001);
				end
			endcase
		end
	end

	// A counter write hides the compare match on the next tick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			block_reg <= 1'b0;
		end else if (cnt_wr) begin
			block_reg <= 1'b1;
		end else if (tick) begin
			block_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Compare buffers, update point and flags
	// ----------------------------------------------------------------
	always_comb begin
		case (cls)
			T16WM_CLS_FAST: begin
				load_now = at_top;
				ovf_set = at_top;
			end
			T16WM_CLS_PC: begin
				load_now = at_top;
				ovf_set = at_bottom;
			end
			T16WM_CLS_PFC: begin
				load_now = at_bottom;
				ovf_set = at_bottom;
			end
			default: begin
				load_now = 1'b1;
				ovf_set = at_max;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 3; i++) begin
				cmp_buf_reg[i] <= T16WM_RST_VALUE;
				cmp_act_reg[i] <= T16WM_RST_VALUE;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (bus_wr && reg_hit(avs_address, 5'(T16WM_OFF_CMP_A + 5'(4 * i)))) begin
					cmp_buf_reg[i] <= avs_writedata[15:0];
				end
				if (load_now) begin
					cmp_act_reg[i] <= cmp_buf_reg[i];
				end
			end
		end
	end

	// Sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ovf_reg <= 1'b0;
			match_flag_reg <= 3'h0;
		end else begin
			if (ovf_set) begin
				ovf_reg <= 1'b1;
			end else if (bus_wr && reg_hit(avs_address, T16WM_OFF_STATUS) && avs_writedata[T16WM_POS_OVF_FLAG]) begin
				ovf_reg <= 1'b0;
			end
			for (int i = 0; i < 3; i++) begin
				if (match[i]) begin
					match_flag_reg[i] <= 1'b1;
				end else if (bus_wr && reg_hit(avs_address, T16WM_OFF_STATUS) &&
					avs_writedata[T16WM_POS_MATCH_FLAG + i]) begin
					match_flag_reg[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Waveform outputs per channel
	// ----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			logic w_next;
			assign match[ch] = tick && !block_reg && (cnt_reg == cmp_act_reg[ch]);
			always_comb begin
				w_next = wave_reg[ch];
				case (cls)
					T16WM_CLS_NORMAL, T16WM_CLS_CTC: begin
						if (match[ch]) begin
							case (out_mode[ch])
								2'b01: w_next = !wave_reg[ch];
								2'b10: w_next = 1'b0;
								2'b11: w_next = 1'b1;
								default: w_next = wave_reg[ch];
							endcase
						end
					end
					T16WM_CLS_FAST: begin
						if (at_top && out_mode[ch][1]) begin
							w_next = !out_mode[ch][0];
						end else if (match[ch] && out_mode[ch][1] && cmp_act_reg[ch] != top) begin
							w_next = out_mode[ch][0];
						end else if (match[ch] && out_mode[ch] == 2'b01 && toggle_ok(ch, cls, mode)) begin
							w_next = !wave_reg[ch];
						end
					end
					T16WM_CLS_PC, T16WM_CLS_PFC: begin
						if (match[ch] && out_mode[ch][1]) begin
							w_next = up_reg ? out_mode[ch][0] : !out_mode[ch][0];
						end else if (match[ch] && out_mode[ch] == 2'b01 && toggle_ok(ch, cls, mode)) begin
							w_next = !wave_reg[ch];
						end
					end
					default: w_next = wave_reg[ch];
				endcase
			end
			assign wave_next[ch] = w_next;
			// Mode 01 where toggling is not offered leaves the port in charge
			assign wave_override[ch] = (out_mode[ch] != 2'b00) && (cls != T16WM_CLS_RSVD) &&
				!(out_mode[ch] == 2'b01 && !toggle_ok(ch, cls, mode));
			assign pin_out[ch] = wave_override[ch] ? wave_reg[ch] : port_out[ch];
			assign pin_oe[ch] = port_dir[ch];
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wave_reg <= 3'h0;
		end else begin
			wave_reg <= wave_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_tick_enable: assert property (!tick && !cnt_wr |=> $stable(cnt_reg))
		else $error("counter moved without a tick");
	a_stop_select: assert property (ctrl_b_reg[2:0] == T16WM_TICK_STOP && !cnt_wr |=> $stable(cnt_reg))
		else $error("stopped counter moved");
	a_nonpwm_toggle: assert property ((cls == T16WM_CLS_NORMAL) && out_mode[0] == 2'b01 && match[0]
		|=> wave_reg[0] != $past(wave_reg[0]) && pin_out[0] == wave_reg[0])
		else $error("non-PWM toggle missing");
	a_fast_clear: assert property ((cls == T16WM_CLS_FAST) && out_mode[1] == 2'b10 && match[1] && !at_top
		|=> !wave_reg[1])
		else $error("fast PWM clear on match missing");
	a_fast_top_ignore: assert property ((cls == T16WM_CLS_FAST) && out_mode[0] == 2'b10 && at_top
		&& cmp_act_reg[0] == top |=> wave_reg[0])
		else $error("fast PWM bottom set missing");
	a_chan_b_toggle: assert property ((cls != T16WM_CLS_NORMAL) && (cls != T16WM_CLS_CTC)
		&& out_mode[1] == 2'b01 |-> !wave_override[1])
		else $error("channel B connected in PWM toggle mode");
	a_dual_up_clear: assert property ((cls == T16WM_CLS_PC) && out_mode[2] == 2'b10 && match[2] && up_reg
		|=> !wave_reg[2])
		else $error("dual-slope up-count clear missing");
	a_fixed_top: assert property (mode == 4'h2 |-> top == T16WM_TOP_9BIT)
		else $error("fixed TOP wrong");
	a_fast_ovf: assert property ((cls == T16WM_CLS_FAST) && at_top |=> ovf_reg && cnt_reg == T16WM_BOTTOM)
		else $error("fast PWM TOP event wrong");
	a_normal_wrap: assert property (mode == 4'h0 && at_max && !cnt_wr |=> cnt_reg == T16WM_BOTTOM && ovf_reg)
		else $error("normal wrap or overflow wrong");
	a_pfc_load: assert property ((cls == T16WM_CLS_PFC) && at_bottom
		|=> cmp_act_reg[1] == $past(cmp_buf_reg[1]) && ovf_reg)
		else $error("BOTTOM load wrong");
	a_dual_reverse: assert property ((cls == T16WM_CLS_PC) && up_reg && at_top && top != 16'h0000 && !cnt_wr
		|=> !up_reg && cnt_reg == 16'($past(cnt_reg) - 16'h0001))
		else $error("dual-slope reversal wrong");
	a_reserved_off: assert property (mode == 4'hd |-> wave_override == 3'h0)
		else $error("reserved mode drove outputs");

	c_fast_pwm: cover property ((cls == T16WM_CLS_FAST) && at_top && out_mode[0] == 2'b10);
	c_dual_turn: cover property ((cls == T16WM_CLS_PFC) && at_bottom && !up_reg);
	c_flag_race: cover property (ovf_set && bus_wr && avs_address == T16WM_OFF_STATUS);
	c_ext_tick: cover property (ctrl_b_reg[2:0] == T16WM_TICK_EXT_FALL && tick);

endmodule
`default_nettype wire

// File: tb/timer16_waveform_mode_control_tb_top.sv
// Self-checking bench for the 16-bit timer waveform and compare-output core.
// Assumes the core's Avalon-MM slave answers after one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_mode_control_tb_top;
	import t16wm_pkg::*;

	// --------------------------------------------------------------
	// Signals and core instance
	// --------------------------------------------------------------
	logic clk, rst_b, avs_read, avs_write, ext_tick_pin;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic avs_waitrequest;
	logic [2:0] port_out, port_dir, pin_out, pin_oe, wave_override;
	int num_errors = 0;
	int comparisons = 0;

	t16wm_core dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_tick_pin(ext_tick_pin), .port_out(port_out),
		.port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe), .wave_override(wave_override));

	// --------------------------------------------------------------
	// Clock, checks and bus tasks
	// --------------------------------------------------------------
	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic final_report();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One edge passes first so a strobe is never raised in the step that dropped it
	task automatic xfer(input logic [4:0] a, input logic wr_en, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) chk("bus answer", 32'h0, 32'h1);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		xfer(a, 1'b0, 32'h0, q);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	// Reset values of the control and counter registers
	task automatic reset_values();
		logic [31:0] q;
		rd(T16WM_OFF_CTRL_A, q);
		chk("control a reset", 32'h0, q);
		rd(T16WM_OFF_CTRL_B, q);
		chk("control b reset", 32'h0, q);
		rd(T16WM_OFF_COUNT, q);
		chk("count reset", 32'h0, q);
	endtask

	// Normal mode: A toggles, B clears, C sets; second pass proves the toggle
	task automatic normal_actions();
		wr(T16WM_OFF_CMP_A, 32'h5);
		wr(T16WM_OFF_CMP_B, 32'h5);
		wr(T16WM_OFF_CMP_C, 32'h5);
		wr(T16WM_OFF_CTRL_A, 32'h6c);
		for (int p = 0; p < 2; p++) begin
			wr(T16WM_OFF_COUNT, 32'h0);
			wr(T16WM_OFF_CTRL_B, {29'h0, T16WM_TICK_DIV1});
			repeat (20) @(posedge clk);
			wr(T16WM_OFF_CTRL_B, {29'h0, T16WM_TICK_STOP});
			chk("pins normal", (p == 0) ? 32'h5 : 32'h4, {29'h0, pin_out});
		end
		chk("override normal", 32'h7, {29'h0, wave_override});
		chk("pin enable", {29'h0, port_dir}, {29'h0, pin_oe});
	endtask

	// External falling edges advance the counter once each, after the filter
	task automatic ext_count();
		logic [31:0] q;
		wr(T16WM_OFF_COUNT, 32'h0);
		wr(T16WM_OFF_CTRL_B, {29'h0, T16WM_TICK_EXT_FALL});
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			ext_tick_pin <= 1'b1;
			repeat (8) @(posedge clk);
			ext_tick_pin <= 1'b0;
			repeat (8) @(posedge clk);
		end
		wr(T16WM_OFF_CTRL_B, {29'h0, T16WM_TICK_STOP});
		rd(T16WM_OFF_COUNT, q);
		chk("external ticks", 32'h3, q);
	endtask

	// Every mode with A and B at 01 and C at 00; masks give who may toggle
	task automatic override_table();
		logic [3:0] mv;
		logic [31:0] q;
		logic [15:0] a_mask;
		logic [15:0] b_mask;
		a_mask = 16'h9a11;
		b_mask = 16'h1011;
		for (int m = 0; m < 16; m++) begin
			mv = m[3:0];
			wr(T16WM_OFF_CTRL_A, {24'h0, 4'h5, 2'b00, mv[1:0]});
			wr(T16WM_OFF_CTRL_B, {27'h0, mv[3:2], 3'h0});
			rd(T16WM_OFF_CTRL_A, q);
			chk("control a", {24'h0, 4'h5, 2'b00, mv[1:0]}, q);
			chk("override", {30'h0, b_mask[m], a_mask[m]}, {29'h0, wave_override});
			chk("pin c port", {31'h0, port_out[2]}, {31'h0, pin_out[2]});
		end
	endtask

	// Run past one period, stop the tick, judge waves from count and direction
	task automatic run_freeze(input logic [1:0] hi, input int dly, input logic [15:0] cmp, input logic dual);
		logic [31:0] cnt, st;
		logic a_exp;
		wr(T16WM_OFF_STATUS, 32'hf);
		wr(T16WM_OFF_COUNT, 32'h0);
		wr(T16WM_OFF_CTRL_B, {27'h0, hi, T16WM_TICK_DIV1});
		repeat (dly) @(posedge clk);
		wr(T16WM_OFF_CTRL_B, {27'h0, hi, T16WM_TICK_STOP});
		rd(T16WM_OFF_COUNT, cnt);
		rd(T16WM_OFF_STATUS, st);
		a_exp = (dual && st[T16WM_POS_COUNT_UP] !== 1'b1) ? (cnt[15:0] < cmp) : (cnt[15:0] <= cmp);
		chk("wave a", {31'h0, a_exp}, {31'h0, pin_out[0]});
		chk("wave b", {31'h0, !a_exp}, {31'h0, pin_out[1]});
		chk("overflow", 32'h1, {31'h0, st[T16WM_POS_OVF_FLAG]});
		chk("match flags", 32'h7, {29'h0, st[3:1]});
	endtask

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	// Whole run needs well under 15000 cycles
	initial begin
		#(30000 * 4);
		num_errors++;
		final_report();
	end

	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		ext_tick_pin = 1'b0;
		port_out = 3'b010;
		port_dir = 3'b110;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		reset_values();
		normal_actions();
		ext_count();
		override_table();
		wr(T16WM_OFF_CMP_A, 32'h10);
		wr(T16WM_OFF_CMP_B, 32'h10);
		wr(T16WM_OFF_CTRL_A, 32'hb1);
		run_freeze(2'b01, 262, 16'h10, 1'b0);
		run_freeze(2'b01, 300, 16'h10, 1'b0);
		run_freeze(2'b01, 700, 16'h10, 1'b0);
		wr(T16WM_OFF_CMP_A, 32'h40);
		wr(T16WM_OFF_CMP_B, 32'h40);
		run_freeze(2'b00, 560, 16'h40, 1'b1);
		run_freeze(2'b00, 600, 16'h40, 1'b1);
		run_freeze(2'b00, 900, 16'h40, 1'b1);
		run_freeze(2'b00, 1000, 16'h40, 1'b1);
		final_report();
	end
endmodule
`default_nettype wire
